/* verilog/pbc_cfg.svh */
// Constants for the basic control register bank: field positions,
// reset values and the register address.
// Assumes inclusion by the reset sequencer and the basic control module only.
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH
`define PBC_ADDR_CTRL 5'h00
`define PBC_BIT_RESET 15
`define PBC_BIT_LOOP 14
`define PBC_BIT_SPEED 13
`define PBC_BIT_ANEN 12
`define PBC_BIT_PDOWN 11
`define PBC_BIT_ISO 10
`define PBC_BIT_RESTART 9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COLTEST 7
`define PBC_RSVD_ZERO 7'h00
`define PBC_RST_LEN 4'h8
`define PBC_ZERO16 16'h0000
`endif

/* verilog/pbc_pkg.sv */
// Types shared by the basic control register bank.
// Assumes pbc_cfg.svh sits on the include path.
package pbc_pkg;
  // Strap levels latched at reset
  typedef struct packed {
    logic speed;
    logic autoneg;
    logic isolate;
    logic duplex;
  } pbc_strap_s;
  // Register write/read port from the management serial logic
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pbc_req_s;
  // Controls driven into the transceiver core
  typedef struct packed {
    logic soft_reset;
    logic loopback;
    logic speed_100;
    logic autoneg_en;
    logic autoneg_restart;
    logic power_down;
    logic isolate;
    logic full_duplex;
    logic col_test;
  } pbc_ctrl_s;
  // Reset sequencer states
  typedef enum logic [2:0] {
    PBC_RUN = 3'b001,
    PBC_HOLD = 3'b010,
    PBC_LATCH = 3'b100
  } pbc_rst_e;
endpackage

/* verilog/pbc_sync2.sv */
// Two-flop synchroniser for one strap pin level.
// Assumes the pin is quasi-static around reset.
`timescale 1ns/1ns
module pbc_sync2
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Level in and out
  input wire logic d_i,
  output logic q_o
);
  logic s1_q; // First stage, read only by second
  // Two-stage shift
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      s1_q <= d_i;
      q_o <= s1_q;
    end
  end
endmodule

/* verilog/pbc_rst_seq.sv */
// Reset sequencer: holds the software reset for a short stretch,
// then asks the register bank to re-latch straps.
// Assumes a one-cycle start pulse from the register bank.
`timescale 1ns/1ns
`include "pbc_cfg.svh"
module pbc_rst_seq
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  output logic busy_o,
  output logic latch_o
);
  import pbc_pkg::*;
  pbc_rst_e state_q; // Sequencer state
  logic [3:0] cnt_q; // Hold counter
  // State and counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Hardware reset runs the same hold as a software reset, so the
      // strap synchronisers have settled before the latch cycle
      state_q <= PBC_HOLD;
      cnt_q <= `PBC_RST_LEN;
    end
    else
    begin
      case (state_q)
        PBC_RUN:
        begin
          if (start_i)
          begin
            state_q <= PBC_HOLD;
            cnt_q <= `PBC_RST_LEN;
          end
        end
        PBC_HOLD:
        begin
          // Hold core in reset for a fixed stretch
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1)
            state_q <= PBC_LATCH;
        end
        default:
          state_q <= PBC_RUN;
      endcase
    end
  end
  assign busy_o = (state_q != PBC_RUN);
  assign latch_o = (state_q == PBC_LATCH);
endmodule

/* verilog/pbc_basic_ctrl.sv */
// Basic control register of the transceiver: holds mode controls,
// strap defaults, self-clearing reset and restart bits.
// Assumes register requests come from the management serial logic
// on the same clock, and strap pins are asynchronous levels.
`timescale 1ns/1ns
`include "pbc_cfg.svh"
module pbc_basic_ctrl
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // Strap pins
  input wire pbc_pkg::pbc_strap_s STRAP_I,
  // Register request
  input wire pbc_pkg::pbc_req_s REQ_I,
  // Register read data
  output logic [15:0] RDATA_O,
  output logic RVALID_O,
  // Controls to the transceiver core
  output pbc_pkg::pbc_ctrl_s CTRL_O,
  // Effective mode after the autoneg override
  output logic EFF_SPEED_100_O,
  output logic EFF_FULL_DUPLEX_O,
  // Result from the negotiation engine
  input wire logic AN_SPEED_100_I,
  input wire logic AN_FULL_DUPLEX_I
);
  import pbc_pkg::*;

  // Synchronised strap levels
  logic strap_speed;
  logic strap_an;
  logic strap_iso;
  logic strap_dup;

  // Register fields
  logic loop_q;
  logic speed_q;
  logic an_q;
  logic pdown_q;
  logic iso_q;
  logic dup_q;
  logic col_q;
  logic restart_q; // One-cycle restart pulse, also readback
  logic sw_rst_q; // Software reset start pulse

  // Sequencer outputs
  logic seq_busy;
  logic seq_latch;

  // Decode of the register access
  wire hit = (REQ_I.addr == `PBC_ADDR_CTRL);
  wire wr_hit = REQ_I.wr && hit && !seq_busy;
  wire rst_wr = wr_hit && REQ_I.wdata[`PBC_BIT_RESET];
  // First reset write while powered down only clears power-down
  wire rst_full = rst_wr && !pdown_q;
  wire rst_pd_exit = rst_wr && pdown_q;
  wire plain_wr = wr_hit && !rst_wr;

  // One synchroniser per strap pin
  pbc_sync2 u_sync_speed (.clk_i(CLK_SYS_I), .rst_i(RESET_I), .d_i(STRAP_I.speed), .q_o(strap_speed));
  pbc_sync2 u_sync_an (.clk_i(CLK_SYS_I), .rst_i(RESET_I), .d_i(STRAP_I.autoneg), .q_o(strap_an));
  pbc_sync2 u_sync_iso (.clk_i(CLK_SYS_I), .rst_i(RESET_I), .d_i(STRAP_I.isolate), .q_o(strap_iso));
  pbc_sync2 u_sync_dup (.clk_i(CLK_SYS_I), .rst_i(RESET_I), .d_i(STRAP_I.duplex), .q_o(strap_dup));

  // Reset sequencer; its latch state re-loads straps, which gives the
  // synchronisers time to settle after hardware reset
  pbc_rst_seq u_seq
  (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .start_i(sw_rst_q),
    .busy_o(seq_busy),
    .latch_o(seq_latch)
  );

  // Self-clearing pulses
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      sw_rst_q <= 1'b0;
      restart_q <= 1'b0;
    end
    else
    begin
      sw_rst_q <= rst_full;
      restart_q <= plain_wr && REQ_I.wdata[`PBC_BIT_RESTART];
    end
  end

  // Control fields
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      loop_q <= 1'b0;
      pdown_q <= 1'b0;
      col_q <= 1'b0;
      speed_q <= 1'b0;
      an_q <= 1'b0;
      iso_q <= 1'b0;
      dup_q <= 1'b0;
    end
    else if (seq_latch)
    begin
      // Strap defaults after any reset
      loop_q <= 1'b0;
      pdown_q <= 1'b0;
      col_q <= 1'b0;
      speed_q <= strap_speed;
      an_q <= strap_an;
      iso_q <= strap_iso;
      dup_q <= ~strap_dup;
    end
    else if (rst_pd_exit)
    begin
      pdown_q <= 1'b0;
    end
    else if (plain_wr)
    begin
      loop_q <= REQ_I.wdata[`PBC_BIT_LOOP];
      speed_q <= REQ_I.wdata[`PBC_BIT_SPEED];
      an_q <= REQ_I.wdata[`PBC_BIT_ANEN];
      pdown_q <= REQ_I.wdata[`PBC_BIT_PDOWN];
      iso_q <= REQ_I.wdata[`PBC_BIT_ISO];
      dup_q <= REQ_I.wdata[`PBC_BIT_DUPLEX];
      col_q <= REQ_I.wdata[`PBC_BIT_COLTEST];
    end
  end

  // Readback word; reserved bits are constant zero
  wire [15:0] rd_word = {seq_busy, loop_q, speed_q, an_q, pdown_q, iso_q,
                         restart_q, dup_q, col_q, `PBC_RSVD_ZERO};
  // Autoneg result overrides the manual bits
  wire eff_spd = an_q ? AN_SPEED_100_I : speed_q;
  wire eff_dup = an_q ? AN_FULL_DUPLEX_I : dup_q;

  // Registered outputs
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      RDATA_O <= `PBC_ZERO16;
      RVALID_O <= 1'b0;
      CTRL_O <= '0;
      EFF_SPEED_100_O <= 1'b0;
      EFF_FULL_DUPLEX_O <= 1'b0;
    end
    else
    begin
      RVALID_O <= REQ_I.rd;
      // Unmapped addresses read zero
      RDATA_O <= (REQ_I.rd && hit) ? rd_word : `PBC_ZERO16;
      CTRL_O.soft_reset <= seq_busy;
      CTRL_O.loopback <= loop_q;
      CTRL_O.speed_100 <= speed_q;
      CTRL_O.autoneg_en <= an_q;
      CTRL_O.autoneg_restart <= restart_q;
      CTRL_O.power_down <= pdown_q;
      CTRL_O.isolate <= iso_q;
      CTRL_O.full_duplex <= dup_q;
      CTRL_O.col_test <= col_q;
      EFF_SPEED_100_O <= eff_spd;
      EFF_FULL_DUPLEX_O <= eff_dup;
    end
  end
endmodule

/* tb/pbc_checker.sv */
// Port assertions for the basic control register bank.
// Assumes pbc_pkg is compiled first; bound to pbc_basic_ctrl.
`timescale 1ns/1ns
module pbc_checker
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // Inputs watched
  input wire pbc_pkg::pbc_strap_s STRAP_I,
  input wire pbc_pkg::pbc_req_s REQ_I,
  input wire logic AN_SPEED_100_I,
  input wire logic AN_FULL_DUPLEX_I,
  // Outputs watched
  input wire logic [15:0] RDATA_O,
  input wire logic RVALID_O,
  input wire pbc_pkg::pbc_ctrl_s CTRL_O,
  input wire logic EFF_SPEED_100_O,
  input wire logic EFF_FULL_DUPLEX_O
);
  import pbc_pkg::*;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  // Settled negotiation result; five cycles hide the output lag
  sequence s_an_hold;
    (CTRL_O.autoneg_en && !CTRL_O.soft_reset && $stable({AN_SPEED_100_I, AN_FULL_DUPLEX_I}))[*5];
  endsequence
  // Settled register mode with negotiation off
  sequence s_reg_hold;
    (!CTRL_O.autoneg_en && !CTRL_O.soft_reset && $stable(CTRL_O))[*5];
  endsequence
  chk_read_answer: assert property (REQ_I.rd |=> RVALID_O && RDATA_O[6:0] == 7'h00)
    else $error("read answer late or reserved bits set");
  chk_restart_pulse: assert property (CTRL_O.autoneg_restart |=> !CTRL_O.autoneg_restart)
    else $error("restart not cleared");
  chk_restart_cause: assert property ($rose(CTRL_O.autoneg_restart) |-> $past(REQ_I.wr, 2) && $past(REQ_I.wdata[9], 2))
    else $error("restart without write");
  chk_eff_negotiated: assert property (s_an_hold |-> {EFF_SPEED_100_O, EFF_FULL_DUPLEX_O} == {AN_SPEED_100_I, AN_FULL_DUPLEX_I})
    else $error("negotiated mode not applied");
  chk_eff_speed_reg: assert property (s_reg_hold |-> EFF_SPEED_100_O == CTRL_O.speed_100)
    else $error("speed bit not applied");
  chk_eff_duplex_reg: assert property (s_reg_hold |-> EFF_FULL_DUPLEX_O == CTRL_O.full_duplex)
    else $error("duplex bit not applied");
  chk_reset_clears: assert property ($fell(CTRL_O.soft_reset) |-> !(CTRL_O.loopback || CTRL_O.power_down || CTRL_O.col_test))
    else $error("soft reset left modes set");
  chk_soft_hold: assert property ($rose(CTRL_O.soft_reset) |-> CTRL_O.soft_reset[*8])
    else $error("soft reset too short");
  chk_soft_ends: assert property ($rose(CTRL_O.soft_reset) |-> ##[1:16] !CTRL_O.soft_reset)
    else $error("soft reset never clears");
endmodule
bind pbc_basic_ctrl pbc_checker pbc_checker_i (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .STRAP_I(STRAP_I),
  .REQ_I(REQ_I), .AN_SPEED_100_I(AN_SPEED_100_I), .AN_FULL_DUPLEX_I(AN_FULL_DUPLEX_I), .RDATA_O(RDATA_O),
  .RVALID_O(RVALID_O), .CTRL_O(CTRL_O), .EFF_SPEED_100_O(EFF_SPEED_100_O), .EFF_FULL_DUPLEX_O(EFF_FULL_DUPLEX_O));

/* tb/pbc_mgr_model.sv */
// Management-side model: issues register reads and writes.
// Assumes the bank answers exactly one cycle after a read.
`timescale 1ns/1ns
module pbc_mgr_model
(
  // Clock
  input wire logic clk_i,
  // Answer from the bank
  input wire logic rvalid_i,
  input wire logic [15:0] rdata_i,
  // Request to the bank
  output pbc_pkg::pbc_req_s req_o
);
  import pbc_pkg::*;
  initial req_o = '0;
  // One-cycle write; released lines show the inverse value
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i) req_o <= '{1'b1, 1'b0, a, d};
    @(posedge clk_i) req_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // One-cycle read; answer sampled mid-cycle to avoid races
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i) req_o <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_i) req_o <= '{1'b0, 1'b0, ~a, 16'hFFFF};
    @(negedge clk_i) d = rvalid_i ? rdata_i : 16'hBAD0;
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the basic control register bank.
// Assumes package, design, checker and model compiled before.
`timescale 1ns/1ns
module testbench;
  import pbc_pkg::*;
  logic CLK_SYS_I = 1'b0;
  logic RESET_I = 1'b1;
  pbc_strap_s STRAP_I = 4'b1011; // Speed, autoneg, isolate, duplex
  pbc_req_s REQ_I;
  logic [15:0] RDATA_O;
  logic RVALID_O;
  pbc_ctrl_s CTRL_O;
  logic EFF_SPEED_100_O;
  logic EFF_FULL_DUPLEX_O;
  logic AN_SPEED_100_I = 1'b0;
  logic AN_FULL_DUPLEX_I = 1'b1;
  logic [15:0] v;
  int bad_count = 0;
  int checks = 0;
  always #5 CLK_SYS_I = ~CLK_SYS_I;
  pbc_basic_ctrl pbc_basic_ctrl_i (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .STRAP_I(STRAP_I), .REQ_I(REQ_I),
    .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .CTRL_O(CTRL_O), .EFF_SPEED_100_O(EFF_SPEED_100_O),
    .EFF_FULL_DUPLEX_O(EFF_FULL_DUPLEX_O), .AN_SPEED_100_I(AN_SPEED_100_I), .AN_FULL_DUPLEX_I(AN_FULL_DUPLEX_I));
  pbc_mgr_model pbc_mgr_model_i (.clk_i(CLK_SYS_I), .rvalid_i(RVALID_O), .rdata_i(RDATA_O), .req_o(REQ_I));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Read one address and compare
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    pbc_mgr_model_i.rd(a, v);
    chk(v, exp);
  endtask
  task automatic wrap_up;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence; CTRL_O packs soft,loop,speed,an,restart,pdown,iso,full,col
  initial
  begin
    repeat (6) @(posedge CLK_SYS_I);
    RESET_I <= 1'b0;
    // Wait out the reset hold and strap latch before the first access
    repeat (12) @(posedge CLK_SYS_I);
    rchk(5'h00, 16'h2400);
    chk(16'(CTRL_O), 16'h0044);
    pbc_mgr_model_i.wr(5'h00, 16'h47FF);
    rchk(5'h00, 16'h4580);
    chk(16'(CTRL_O), 16'h0087);
    chk(16'({EFF_SPEED_100_O, EFF_FULL_DUPLEX_O}), 16'h0001);
    pbc_mgr_model_i.wr(5'h00, 16'h3000);
    repeat (6) @(posedge CLK_SYS_I);
    chk(16'({EFF_SPEED_100_O, EFF_FULL_DUPLEX_O}), 16'h0001);
    AN_SPEED_100_I <= 1'b1;
    AN_FULL_DUPLEX_I <= 1'b0;
    repeat (6) @(posedge CLK_SYS_I);
    chk(16'({EFF_SPEED_100_O, EFF_FULL_DUPLEX_O}), 16'h0002);
    pbc_mgr_model_i.wr(5'h00, 16'h2100);
    repeat (6) @(posedge CLK_SYS_I);
    chk(16'({EFF_SPEED_100_O, EFF_FULL_DUPLEX_O}), 16'h0003);
    pbc_mgr_model_i.wr(5'h00, 16'h0800);
    repeat (3) @(posedge CLK_SYS_I);
    chk(16'(CTRL_O), 16'h0008);
    STRAP_I <= 4'b0100;
    pbc_mgr_model_i.wr(5'h00, 16'h8000);
    rchk(5'h00, 16'h0000);
    pbc_mgr_model_i.wr(5'h00, 16'h8000);
    repeat (2) @(posedge CLK_SYS_I);
    rchk(5'h00, 16'h8000);
    pbc_mgr_model_i.wr(5'h00, 16'h4000);
    repeat (20) @(posedge CLK_SYS_I);
    rchk(5'h00, 16'h1100);
    chk(16'(CTRL_O), 16'h0022);
    pbc_mgr_model_i.wr(5'h01, 16'h4000);
    rchk(5'h00, 16'h1100);
    rchk(5'h01, 16'h0000);
    wrap_up;
  end
  // Watchdog, far beyond the roughly 90 cycles needed
  initial
  begin
    #100000;
    bad_count++;
    wrap_up;
  end
endmodule
